//--- hdl/bpf_defines.svh
// Notes on behaviour
// - Up to four byte-wide bidirectional ports give up to thirty-two usable lines.
// - A port write captures the internal bus into that port's latch, held until rewritten.
// - Pin data is never latched; a read samples the live pin levels at the read.
// - In the cycle after a read strobe, the pins sampled at that edge are driven onto the internal bus.
// - Each line has a weak pull-up that a TTL low can override.
// - A latch bit of one turns off that line's pull-down so an external driver controls the pin.
// - Every bit of a port works alone as an input or an output.
// - The ports sit at file addresses five to eight in order A, B, C, D.
// - Read-modify-write reads pins, so forced zeros may be written back into a latch.
`ifndef BPF_DEFINES_SVH
`define BPF_DEFINES_SVH

`define BPF_FILE_PORT_A 5'h05
`define BPF_FILE_PORT_B 5'h06
`define BPF_FILE_PORT_C 5'h07
`define BPF_FILE_PORT_D 5'h08
`define BPF_LATCH_RESET 8'hff

`endif

//--- hdl/bpf_pkg.sv
package bpf_pkg;
    typedef struct packed {
        logic       write;
        logic       read;
        logic [4:0] fileAddr;
        logic [7:0] data;
    } bpf_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } bpf_rsp_t;
endpackage

//--- hdl/bpf_port_file.sv
`include "bpf_defines.svh"

module bpf_port_file #(
    parameter int NUM_PORTS = 4,
    parameter int WIDTH     = 8
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire bpf_pkg::bpf_req_t          req,
    output bpf_pkg::bpf_rsp_t               rsp,
    input  wire logic [NUM_PORTS*WIDTH-1:0] pinIn,
    output logic      [NUM_PORTS*WIDTH-1:0] pinOutEn_n,
    output logic      [NUM_PORTS*WIDTH-1:0] pullupEn
);
    logic [NUM_PORTS*WIDTH-1:0] latches;
    logic [WIDTH-1:0]           next_rdData;
    logic                       next_hit;
    logic [NUM_PORTS-1:0]       portHit;
    logic                       addrRefused;

    //--------------------------------------------
    // Address decode
    //--------------------------------------------
    // One hit bit per port; a request outside the window hits none
    always_comb
    begin
        portHit = '0;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            if (req.fileAddr == 5'(`BPF_FILE_PORT_A + p))
            begin
                portHit[p] = 1'b1;
            end
        end
    end

    // Refused addresses leave latches and read bus alone
    always_comb
    begin
        addrRefused = ~(|portHit);
    end

    //--------------------------------------------
    // Port latches
    //--------------------------------------------
    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_port
        bpf_port_reg #(
            .FILE_ADDR (5'(`BPF_FILE_PORT_A + p)),
            .WIDTH     (WIDTH)
        ) u_reg (
            .clk      (clk),
            .rst      (rst),
            .write    (req.write),
            .fileAddr (req.fileAddr),
            .wrData   (req.data[WIDTH-1:0]),
            .latch    (latches[p*WIDTH +: WIDTH])
        );
    end

    //--------------------------------------------
    // Pin drive
    //--------------------------------------------
    // Pull-down on only for a zero bit; enable low means driving low
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pinOutEn_n <= '1;
        else
            pinOutEn_n <= latches;
    end

    // Weak pull-up always present; a TTL low overrides it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pullupEn <= '1;
        else
            pullupEn <= '1;
    end

    //--------------------------------------------
    // Read path
    //--------------------------------------------
    // Live pins, never the latch; RMW therefore sees forced zeros
    always_comb
    begin
        next_rdData = '0;
        next_hit    = 1'b0;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            if (req.fileAddr == 5'(`BPF_FILE_PORT_A + p))
            begin
                next_rdData = pinIn[p*WIDTH +: WIDTH];
                next_hit    = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rsp <= '0;
        else
        begin
            rsp.valid <= req.read && next_hit;
            rsp.data  <= (req.read && next_hit) ? 8'(next_rdData) : 8'h00;
        end
    end

    a_read_pins: assert property (@(posedge clk) disable iff (rst)
        (req.read && req.fileAddr == `BPF_FILE_PORT_A)
        |=> rsp.valid && rsp.data == $past(pinIn[WIDTH-1:0]))
        else $error("read did not return pins");
    a_bus_idle: assert property (@(posedge clk) disable iff (rst)
        !req.read |=> !rsp.valid && rsp.data == 8'h00)
        else $error("bus driven without read");
    a_release_one: assert property (@(posedge clk) disable iff (rst)
        (req.write && req.fileAddr == `BPF_FILE_PORT_B) |=> ##1
        pinOutEn_n[2*WIDTH-1:WIDTH] == $past(req.data[WIDTH-1:0], 2))
        else $error("pull-down not following latch");
    a_pullup_on: assert property (@(posedge clk) disable iff (rst)
        pullupEn == '1)
        else $error("pull-up off");

    //--------------------------------------------
    // Reset release
    //--------------------------------------------
    // First edge after release still shows reset values
    a_reset_clean: assert property (@(posedge clk)
        (!rst && $past(rst)) |-> pinOutEn_n == '1 && pullupEn == '1 && !rsp.valid)
        else $error("outputs not at reset values");

    //--------------------------------------------
    // Refused requests
    //--------------------------------------------
    // A read outside the window must keep the bus quiet
    a_refused_quiet: assert property (@(posedge clk) disable iff (rst)
        (req.read && addrRefused) |=> !rsp.valid && rsp.data == 8'h00)
        else $error("refused read answered");

    // A write outside the window must move no latch
    a_refused_keep: assert property (@(posedge clk) disable iff (rst)
        (req.write && addrRefused) |=> latches == $past(latches))
        else $error("refused write moved a latch");

    //--------------------------------------------
    // Per-port checks
    //--------------------------------------------
    for (genvar q = 0; q < NUM_PORTS; q++)
    begin : g_check
        // Pull-down follows its latch one edge later
        a_pull_follow: assert property (@(posedge clk) disable iff (rst)
            pinOutEn_n[q*WIDTH +: WIDTH] == $past(latches[q*WIDTH +: WIDTH]))
            else $error("pull-down lags latch wrongly");

        // Read returns the pins seen at the read edge
        a_read_port: assert property (@(posedge clk) disable iff (rst)
            (req.read && portHit[q])
            |=> rsp.valid && rsp.data == 8'($past(pinIn[q*WIDTH +: WIDTH])))
            else $error("port read wrong");

        // A read without a write leaves this port's latch unchanged
        a_pins_not_latch: assert property (@(posedge clk) disable iff (rst)
            (req.read && portHit[q] && !req.write)
            |=> $past(latches[q*WIDTH +: WIDTH]) == latches[q*WIDTH +: WIDTH])
            else $error("read disturbed a latch");

        // This port's latch stays put unless this port is written
        a_line_alone: assert property (@(posedge clk) disable iff (rst)
            !(req.write && portHit[q]) |=> $stable(latches[q*WIDTH +: WIDTH]))
            else $error("port latch moved without write");

        // Write lands exactly in this port
        a_port_load: assert property (@(posedge clk) disable iff (rst)
            (req.write && portHit[q])
            |=> latches[q*WIDTH +: WIDTH] == $past(req.data[WIDTH-1:0]))
            else $error("port write lost");
    end

    //--------------------------------------------
    // Write and read together
    //--------------------------------------------
    // Same-cycle read sees pins, not the data just written
    a_rw_same: assert property (@(posedge clk) disable iff (rst)
        (req.read && req.write && portHit[0])
        |=> rsp.data == 8'($past(pinIn[WIDTH-1:0])))
        else $error("read returned written data");

    c_write_d: cover property (@(posedge clk) disable iff (rst)
        req.write && req.fileAddr == `BPF_FILE_PORT_D);
    c_read_c: cover property (@(posedge clk) disable iff (rst)
        req.read && req.fileAddr == `BPF_FILE_PORT_C);
    c_rmw: cover property (@(posedge clk) disable iff (rst)
        req.read && req.fileAddr == `BPF_FILE_PORT_A ##1 req.write);
    c_refused: cover property (@(posedge clk) disable iff (rst)
        req.read && addrRefused);
    c_rw_same: cover property (@(posedge clk) disable iff (rst)
        req.read && req.write && portHit[0]);
endmodule

//--- hdl/bpf_port_reg.sv
`include "bpf_defines.svh"

module bpf_port_reg #(
    parameter logic [4:0] FILE_ADDR = 5'h05,
    parameter int         WIDTH     = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             write,
    input  wire logic [4:0]       fileAddr,
    input  wire logic [WIDTH-1:0] wrData,
    output logic      [WIDTH-1:0] latch
);
    //--------------------------------------------
    // Output latch
    //--------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            latch <= WIDTH'(`BPF_LATCH_RESET);
        else if (write && fileAddr == FILE_ADDR)
            latch <= wrData;
    end

    a_latch_holds: assert property (@(posedge clk) disable iff (rst)
        !(write && fileAddr == FILE_ADDR) |=> latch == $past(latch))
        else $error("latch changed without write");
    a_latch_loads: assert property (@(posedge clk) disable iff (rst)
        (write && fileAddr == FILE_ADDR) |=> latch == $past(wrData))
        else $error("latch missed write");
endmodule

//--- tb/bpf_pins_model.sv
module bpf_pins_model (
    input  wire logic [31:0] pinOutEn_n,
    input  wire logic [31:0] pullupEn,
    input  wire logic [31:0] extLow,
    output logic      [31:0] pinIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // Wired-AND of pull-up, pull-down and open-collector drivers
    assign pinIn = pullupEn & pinOutEn_n & ~extLow;
endmodule

//--- tb/bpf_port_file_tb_top.sv
module bpf_port_file_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk = 0;
    logic              rst = 1;
    bpf_pkg::bpf_req_t req = '0;
    bpf_pkg::bpf_rsp_t rsp;
    logic [31:0]       pinIn, oenN, pu;
    logic [31:0]       extLow = '0;
    logic [7:0]        lat [4];
    logic [7:0]        expq [$];
    int                nErrors = 0, checksDone = 0, cyc = 0;
    int                seed = 32'h8209;
    initial forever #4 clk = ~clk;
    bpf_port_file DUT (.clk(clk), .rst(rst), .req(req), .rsp(rsp), .pinIn(pinIn),
        .pinOutEn_n(oenN), .pullupEn(pu));
    bpf_pins_model ext (.pinOutEn_n(oenN), .pullupEn(pu), .extLow(extLow), .pinIn(pinIn));
    task tally_and_finish;
        if (nErrors == 0 && checksDone > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
        checksDone++;
        if (s !== e)
        begin
            nErrors++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task rd(input int p);
        expq.push_back(lat[p] & ~extLow[p*8+:8]);
        req.write = 0;
        req.read = 1;
        req.fileAddr = 5'(p + 5);
        @(posedge clk) #1;
    endtask
    task wr(input int p, input logic [7:0] d);
        lat[p] = d;
        req.read = 0;
        req.write = 1;
        req.fileAddr = 5'(p + 5);
        req.data = d;
        @(posedge clk) #1;
    endtask
    task idle;
        req = '0;
        repeat (3) @(posedge clk) #1;
    endtask
    always @(posedge clk)
    begin
        #2;
        if (rsp.valid === 1'b1)
            cmp8("rsp.data", expq.size() > 0 ? expq.pop_front() : 8'hxx, rsp.data);
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 2000)
        begin
            nErrors++;
            tally_and_finish;
        end
    end
    initial
    begin
        for (int i = 0; i < 4; i++) lat[i] = 8'hff;
        repeat (10) @(posedge clk);
        #1 rst = 0;
        for (int p = 0; p < 4; p++) rd(p);
        for (int k = 0; k < 3; k++)
        begin
            for (int p = 0; p < 4; p++) wr(p, 8'($random(seed)));
            idle;
            for (int p = 0; p < 4; p++) rd(p);
            for (int p = 0; p < 4; p++) cmp8("pinOutEn_n", lat[p], oenN[p*8+:8]);
            for (int p = 0; p < 4; p++) cmp8("pullupEn", 8'hff, pu[p*8+:8]);
        end
        for (int p = 0; p < 4; p++) wr(p, 8'hff);
        idle;
        for (int k = 0; k < 4; k++)
        begin
            extLow = $random(seed);
            for (int p = 0; p < 4; p++) rd(p);
        end
        req.fileAddr = 5'h09;
        @(posedge clk) #1;
        idle;
        cmp8("queue left", 8'h00, 8'(expq.size()));
        tally_and_finish;
    end
endmodule
